/* caw_watchdog.sv */
// caw_watchdog: communication activity watchdog, one instance.
// assumes io_cmd_seen is a one-cycle pulse from core_clk logic; timer_busy comes
// from the arbiter of other instances and may be asynchronous.
// What this block does
// - enable rising edge starts, status bit 0, checks
// - preset below one second gives fault 1
// - timer held elsewhere gives fault 2
// - command received restarts timer, status bit 2
// - running without command sets status bit 1
// - preset reached gives expiry, status bit 3
// - clear setting selects end-of-scan output clear
// - clear only covers embedded, plugin, expansion digital
// - disabled block clears all outputs except reg_rdata, and clear pins at end_of_scan in its first cycle
// - expiry true only when elapsed equals preset
// - elapsed spans zero to time maximum
// - status eight bits, bits 5-7 zero
// - error output comes with matching fault code
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module caw_watchdog
  import caw_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES = MS_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // activity and arbitration
  input wire logic io_cmd_seen,
  input wire logic timer_busy,
  input wire logic end_of_scan,
  // results
  output logic timed_out,
  output logic error,
  output logic [7:0] fault_code,
  output logic [7:0] status,
  output logic [31:0] elapsed_time,
  output logic clear_embedded_do,
  output logic clear_plugin_module_io,
  output logic clear_expansion_io,
  output logic holds_timer
);

  typedef struct packed {
    caw_state_t state;
    logic enable;
    logic enable_q;
    logic clear_outputs_on_expiry;
    logic [31:0] preset_time;
    logic [31:0] ms_count;
    logic [2:0] busy_sync;
    logic busy;
    logic pending_clear;
    logic [2:0] clear_pins;
    logic holds;
    logic [31:0] rdata;
    caw_out_t out;
  } caw_regs_t;

  caw_regs_t r;
  caw_regs_t next_r;

  always_comb begin
    next_r = r;
    next_r.rdata = 32'h0000_0000;
    next_r.clear_pins = 3'h0;
    next_r.busy_sync = {r.busy_sync[1:0], timer_busy};
    // change accepted only once second and third stages agree
    if (r.busy_sync[2] == r.busy_sync[1]) begin
      next_r.busy = r.busy_sync[2];
    end
    next_r.enable_q = r.enable;

    if (reg_write) begin
      unique case (reg_addr)
        REG_CTRL: begin
          next_r.enable = reg_wdata[CTRL_ENABLE];
          next_r.clear_outputs_on_expiry = reg_wdata[CTRL_CLEAR_OUTPUTS];
        end
        REG_PRESET: next_r.preset_time = reg_wdata;
        default: ;
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        REG_CTRL: next_r.rdata = {30'h0, r.clear_outputs_on_expiry, r.enable};
        REG_PRESET: next_r.rdata = r.preset_time;
        REG_ELAPSED: next_r.rdata = r.out.elapsed_time;
        REG_STATUS: next_r.rdata = {8'h00, r.out.fault_code, r.out.status, 5'h0, r.out.clear_request,
                                    r.out.expired, r.out.error};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end

    if (!r.enable) begin
      next_r.state = CAW_IDLE;
      next_r.out = '0;
      next_r.holds = 1'b0;
      next_r.pending_clear = 1'b0;
      next_r.ms_count = 32'h0;
    end else begin
      unique case (r.state)
        CAW_IDLE: begin
          if (!r.enable_q) begin
            next_r.state = CAW_CHECK;
            next_r.out = '0;
            next_r.out.status[ST_ENABLE] = 1'b1;
          end
        end
        CAW_CHECK: begin
          // error checks before any timing starts
          if (r.preset_time < MIN_PRESET_MS) begin
            next_r.state = CAW_FAULT;
            next_r.out = '0;
            next_r.out.error = 1'b1;
            next_r.out.fault_code = FAULT_SHORT_PRESET;
            next_r.out.status[ST_ERROR] = 1'b1;
          end else if (r.busy) begin
            next_r.state = CAW_FAULT;
            next_r.out = '0;
            next_r.out.error = 1'b1;
            next_r.out.fault_code = FAULT_TIMER_BUSY;
            next_r.out.status[ST_ERROR] = 1'b1;
          end else begin
            next_r.state = CAW_RUN;
            next_r.holds = 1'b1;
            next_r.ms_count = 32'h0;
            next_r.out.elapsed_time = 32'h0;
            next_r.out.status = 8'h00;
            next_r.out.status[ST_RUNNING] = 1'b1;
          end
        end
        CAW_RUN, CAW_EXPIRED: begin
          if (io_cmd_seen) begin
            next_r.state = CAW_RUN;
            next_r.ms_count = 32'h0;
            next_r.out.elapsed_time = 32'h0;
            next_r.out.expired = 1'b0;
            next_r.out.status = 8'h00;
            next_r.out.status[ST_RECEIVED] = 1'b1;
            next_r.pending_clear = 1'b0;
          end else if (r.state == CAW_RUN) begin
            // a fresh restart keeps bit 2 until the timer moves again
            if (r.ms_count >= 32'(MS_TICK_CYCLES - 1)) begin
              next_r.ms_count = 32'h0;
              // wraps nowhere: preset bounds elapsed, and preset fits the time type
              next_r.out.elapsed_time = r.out.elapsed_time + 32'h1;
              next_r.out.status = 8'h00;
              next_r.out.status[ST_RUNNING] = 1'b1;
            end else begin
              next_r.ms_count = r.ms_count + 32'h1;
            end
            if (r.out.elapsed_time >= r.preset_time) begin
              next_r.state = CAW_EXPIRED;
              next_r.out.elapsed_time = r.preset_time;
              next_r.out.expired = 1'b1;
              next_r.out.status = 8'h00;
              next_r.out.status[ST_TIMEOUT] = 1'b1;
              next_r.pending_clear = r.clear_outputs_on_expiry;
            end
          end
        end
        CAW_FAULT: ;
      endcase
    end

    // clearing acts at scan end and only on the digital output groups
    if (r.pending_clear && end_of_scan && r.state == CAW_EXPIRED) begin
      next_r.clear_pins = 3'h7;
      next_r.pending_clear = 1'b0;
    end
    next_r.out.clear_request = r.pending_clear;
    next_r.out.status[7:5] = 3'h0;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{state: CAW_IDLE, preset_time: PRESET_RESET, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rdata;
  assign timed_out = r.out.expired;
  assign error = r.out.error;
  assign fault_code = r.out.fault_code;
  assign status = r.out.status;
  assign elapsed_time = r.out.elapsed_time;
  assign clear_embedded_do = r.clear_pins[0];
  assign clear_plugin_module_io = r.clear_pins[1];
  assign clear_expansion_io = r.clear_pins[2];
  assign holds_timer = r.holds;

endmodule : caw_watchdog

`default_nettype wire

/* caw_pkg.sv */
// caw_pkg: constants and carrier types for the communication activity watchdog.
// assumes a 25 MHz core clock; times are kept in milliseconds, 32 bits.
package caw_pkg;

  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned TICK_MS = 1;
  // cycles per millisecond tick, derived from clock rate
  localparam int unsigned MS_CYCLES = (CLK_HZ / 1000) * TICK_MS;
  localparam int unsigned MIN_PRESET_S = 1;
  localparam logic [31:0] MIN_PRESET_MS = 32'h0000_03e8;
  localparam logic [31:0] TIME_MAX_MS = 32'hffff_ffff;

  // status bit positions
  localparam int unsigned ST_ENABLE = 0;
  localparam int unsigned ST_RUNNING = 1;
  localparam int unsigned ST_RECEIVED = 2;
  localparam int unsigned ST_TIMEOUT = 3;
  localparam int unsigned ST_ERROR = 4;

  // fault codes
  localparam logic [7:0] FAULT_NONE = 8'h00;
  localparam logic [7:0] FAULT_SHORT_PRESET = 8'h01;
  localparam logic [7:0] FAULT_TIMER_BUSY = 8'h02;

  // register offsets on the plain register port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PRESET = 4'h4;
  localparam logic [3:0] REG_ELAPSED = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  localparam int unsigned CTRL_ENABLE = 0;
  localparam int unsigned CTRL_CLEAR_OUTPUTS = 1;
  localparam logic [31:0] PRESET_RESET = 32'h0000_03e8;

  typedef enum {CAW_IDLE, CAW_CHECK, CAW_RUN, CAW_EXPIRED, CAW_FAULT} caw_state_t;

  typedef struct packed {
    logic [31:0] elapsed_time;
    logic [7:0] status;
    logic [7:0] fault_code;
    logic error;
    logic expired;
    logic clear_request;
  } caw_out_t;

endpackage : caw_pkg

/* caw_watchdog_assertions.sv */
// caw_watchdog_assertions: port-level checks of the activity watchdog.
// assumes one core_clk domain and rstn active low.
`timescale 1ns/100ps
`default_nettype none
module caw_watchdog_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // watched signals
  input wire logic io_cmd_seen,
  input wire logic timed_out,
  input wire logic error,
  input wire logic [7:0] fault_code,
  input wire logic [7:0] status,
  input wire logic [31:0] elapsed_time,
  input wire logic clear_embedded_do,
  input wire logic clear_plugin_module_io,
  input wire logic clear_expansion_io
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_status_reserved: assert property (status[7:5] == 3'h0) else $error("reserved status bits set");
  chk_error_code: assert property (error |-> fault_code inside {8'h01, 8'h02}) else $error("bad fault code");
  chk_error_clears: assert property (error |-> !timed_out && elapsed_time == 32'h0 && status == 8'h10)
    else $error("error outputs wrong");
  chk_cmd_restart: assert property (io_cmd_seen && status[3:1] != 3'h0 |=> elapsed_time == 32'h0 && status == 8'h04)
    else $error("command did not restart");
  chk_timeout_state: assert property (timed_out |-> status == 8'h08 && !error && elapsed_time != 32'h0)
    else $error("expiry state wrong");
  chk_ms_step: assert property ($changed(elapsed_time) && elapsed_time != 32'h0 |->
    elapsed_time == $past(elapsed_time) + 32'h1) else $error("elapsed step wrong");
  chk_clear_pulse: assert property (clear_embedded_do |-> clear_plugin_module_io && clear_expansion_io && timed_out
    ##1 !clear_embedded_do) else $error("clear pulse wrong");
  chk_run_status: assert property (status == 8'h02 |-> !timed_out && !error) else $error("run state wrong");
endmodule : caw_watchdog_assertions
bind caw_watchdog caw_watchdog_assertions chk (.core_clk, .rstn, .io_cmd_seen, .timed_out, .error, .fault_code,
  .status, .elapsed_time, .clear_embedded_do, .clear_plugin_module_io, .clear_expansion_io);
`default_nettype wire

/* caw_net_master.sv */
// caw_net_master: network master that issues I/O command pulses.
// assumes cmd_gap 0 means silent; otherwise one pulse every cmd_gap+1 cycles.
`timescale 1ns/100ps
`default_nettype none
module caw_net_master (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // traffic setting
  input wire logic [15:0] cmd_gap,
  // command pulses
  output logic io_cmd_seen
);
  logic [15:0] cnt;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 16'h0;
      io_cmd_seen <= 1'b0;
    end else begin
      io_cmd_seen <= (cmd_gap != 16'h0) && (cnt == cmd_gap);
      cnt <= (cnt >= cmd_gap) ? 16'h0 : cnt + 16'h1;
    end
  end
endmodule : caw_net_master
`default_nettype wire

/* caw_watchdog_bench.sv */
// caw_watchdog_bench: register-driven tests of the activity watchdog.
// assumes a 1 ms tick shortened to 4 cycles; master model makes commands.
`timescale 1ns/100ps
`default_nettype none
module caw_watchdog_bench;
  import caw_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, timer_busy = 1'b0, end_of_scan = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, elapsed_time;
  logic timed_out, error, holds_timer, clear_embedded_do, clear_plugin_module_io, clear_expansion_io, io_cmd_seen;
  logic [7:0] fault_code, status;
  logic [15:0] cmd_gap = 16'h0;
  int n_mismatch = 0, check_count = 0;
  always #20 core_clk = ~core_clk;
  caw_watchdog #(.MS_TICK_CYCLES(4)) uut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .io_cmd_seen, .timer_busy, .end_of_scan, .timed_out, .error, .fault_code, .status,
    .elapsed_time, .clear_embedded_do, .clear_plugin_module_io, .clear_expansion_io, .holds_timer);
  caw_net_master nm (.core_clk, .rstn, .cmd_gap, .io_cmd_seen);
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 check(reg_rdata, e);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic final_report;
    $display("mismatches %0d of %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    rd(REG_PRESET, PRESET_RESET);
    rd(4'h2, 32'h0);
    wr(REG_PRESET, 32'h3e7);
    wr(REG_CTRL, 32'h1);
    settle(4);
    rd(REG_STATUS, 32'h0001_1001);
    wr(REG_CTRL, 32'h0);
    settle(2);
    check({error, fault_code, status, elapsed_time, timed_out}, 64'h0);
    timer_busy <= 1'b1;
    wr(REG_PRESET, 32'h3e8);
    wr(REG_CTRL, 32'h1);
    settle(6);
    check({error, fault_code, status, holds_timer}, {1'b1, FAULT_TIMER_BUSY, 8'h10, 1'b0});
    wr(REG_CTRL, 32'h0);
    timer_busy <= 1'b0;
    // let the busy level pass the three-stage synchroniser before re-enabling
    settle(6);
    // both clear settings: expiry action only when set
    for (int c = 1; c >= 0; c--) begin
      wr(REG_CTRL, {30'h0, c[0], 1'b1});
      settle(6);
      check({status, holds_timer}, {8'h02, 1'b1});
      cmd_gap <= 16'd100;
      settle(400);
      check({timed_out, 31'h0, elapsed_time < 32'd30}, 64'h1);
      cmd_gap <= 16'h0;
      for (int i = 0; i < 5000 && timed_out !== 1'b1; i++) @(posedge core_clk);
      settle(2);
      check({status, elapsed_time}, {8'h08, 32'h3e8});
      rd(REG_ELAPSED, 32'h0000_03e8);
      @(posedge core_clk);
      end_of_scan <= 1'b1;
      @(posedge core_clk);
      end_of_scan <= 1'b0;
      #1 check({clear_embedded_do, clear_plugin_module_io, clear_expansion_io}, {3{c[0]}});
      wr(REG_CTRL, 32'h0);
    end
    final_report();
  end
endmodule : caw_watchdog_bench
`default_nettype wire
